// File: verilog/mmu_config_protection_regs.sv
// Purpose: translation configuration, group protection and space id registers
// Assumes: special-register moves arrive as one-cycle strobes on the core clock
// Notes: lookup answers are registered, one cycle after their inputs
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1 - group mode bit selects key or domain
// R2 - page mode bit selects page or subpage
// R3 - instruction fetch inhibit default when untranslated
// R4 - data inhibit, writethrough defaults when untranslated
// R5 - reserved control bits ignore writes, read zero
// R6 - instruction pointer modulo eight or six
// R7 - data pointer modulo eight or six
// R8 - state compare mode uses entry state bits
// R9 - instruction pointer decrements per instruction load
// R10 - data pointer decrements per data load
// R11 - walk assist bit selects subpage or page
// R12 - domain codes: deny, client, reserved, manager
// R13 - key codes: privileged, pages, swapped, problem
// R14 - sixteen two-bit group codes per register
// R15 - space id compared; upper bits reserved
// R16 - global entry ignores space id compare
// R17 - protection and space registers not reset
// R18 - software accesses only with translation off
// R19 - pointer wraps from zero to range top
module mmu_config_protection_regs (
	input wire logic clk_i,
	input wire logic rst_n_i,
	// special-register move port
	input wire logic spr_wr_i,
	input wire logic spr_rd_i,
	input wire logic [mmu_cfg_pkg::SPR_W-1:0] spr_num_i,
	input wire logic [mmu_cfg_pkg::WORD_W-1:0] spr_wdata_i,
	output logic [mmu_cfg_pkg::WORD_W-1:0] spr_rdata_o,
	output logic spr_rvalid_o,
	// translation enables from the machine state
	input wire logic instr_xlate_en_i,
	input wire logic data_xlate_en_i,
	// instruction lookup
	input wire logic [mmu_cfg_pkg::GRP_W-1:0] instr_group_i,
	input wire logic instr_problem_i,
	input wire logic instr_entry_ci_i,
	input wire logic [mmu_cfg_pkg::SID_W-1:0] instr_entry_space_id_i,
	input wire logic instr_global_entry_flag_i,
	input wire logic [mmu_cfg_pkg::STATE_W-1:0] instr_entry_state_i,
	output logic instr_deny_o,
	output logic instr_check_pages_o,
	output logic instr_eff_problem_o,
	output logic instr_hit_qual_o,
	output logic instr_fetch_inhibit_o,
	// data lookup
	input wire logic [mmu_cfg_pkg::GRP_W-1:0] data_group_i,
	input wire logic data_problem_i,
	input wire logic data_entry_ci_i,
	input wire logic data_entry_wt_i,
	input wire logic [mmu_cfg_pkg::SID_W-1:0] data_entry_space_id_i,
	input wire logic data_global_entry_flag_i,
	input wire logic [mmu_cfg_pkg::STATE_W-1:0] data_entry_state_i,
	output logic data_deny_o,
	output logic data_check_pages_o,
	output logic data_eff_problem_o,
	output logic data_hit_qual_o,
	output logic data_access_inhibit_o,
	output logic data_access_wrthru_o,
	// mode levels for the translation logic
	output logic instr_subpage_mode_o,
	output logic data_subpage_mode_o,
	output logic walk_assist_size_o,
	output logic [mmu_cfg_pkg::PTR_W-1:0] instr_replace_pointer_o,
	output logic [mmu_cfg_pkg::PTR_W-1:0] data_replace_pointer_o
);
	////////////////////////////////////////////////////////////////////////////////
	// control registers
	logic i_gmode_ff, i_pmode_ff, i_inh_ff, i_rsv_ff, i_scmp_ff;
	logic d_gmode_ff, d_pmode_ff, d_inh_ff, d_wt_ff, d_rsv_ff, d_walk_ff, d_scmp_ff;
	logic nxt_i_gmode, nxt_i_pmode, nxt_i_inh, nxt_i_rsv, nxt_i_scmp;
	logic nxt_d_gmode, nxt_d_pmode, nxt_d_inh, nxt_d_wt, nxt_d_rsv, nxt_d_walk, nxt_d_scmp;
	logic wr_i_ctl, wr_d_ctl, wr_i_grp, wr_d_grp, wr_sid, ld_i_tlb, ld_d_tlb;
	logic [mmu_cfg_pkg::PTR_W-1:0] i_ptr, d_ptr;

	assign wr_i_ctl = spr_wr_i && (spr_num_i == mmu_cfg_pkg::SPR_INSTR_CTL);
	assign wr_d_ctl = spr_wr_i && (spr_num_i == mmu_cfg_pkg::SPR_DATA_CTL);
	assign wr_i_grp = spr_wr_i && (spr_num_i == mmu_cfg_pkg::SPR_INSTR_GRP);
	assign wr_d_grp = spr_wr_i && (spr_num_i == mmu_cfg_pkg::SPR_DATA_GRP);
	assign wr_sid = spr_wr_i && (spr_num_i == mmu_cfg_pkg::SPR_SPACE_ID);
	assign ld_i_tlb = spr_wr_i && (spr_num_i == mmu_cfg_pkg::SPR_INSTR_RPN);
	assign ld_d_tlb = spr_wr_i && (spr_num_i == mmu_cfg_pkg::SPR_DATA_RPN);

	// only defined fields are stored; reserved positions are never kept
	always_comb begin
		nxt_i_gmode = i_gmode_ff;
		nxt_i_pmode = i_pmode_ff;
		nxt_i_inh = i_inh_ff;
		nxt_i_rsv = i_rsv_ff;
		nxt_i_scmp = i_scmp_ff;
		nxt_d_gmode = d_gmode_ff;
		nxt_d_pmode = d_pmode_ff;
		nxt_d_inh = d_inh_ff;
		nxt_d_wt = d_wt_ff;
		nxt_d_rsv = d_rsv_ff;
		nxt_d_walk = d_walk_ff;
		nxt_d_scmp = d_scmp_ff;
		if (wr_i_ctl) begin
			nxt_i_gmode = spr_wdata_i[mmu_cfg_pkg::POS_GROUP_MODE];
			nxt_i_pmode = spr_wdata_i[mmu_cfg_pkg::POS_PAGE_MODE];
			nxt_i_inh = spr_wdata_i[mmu_cfg_pkg::POS_INHIBIT];
			nxt_i_rsv = spr_wdata_i[mmu_cfg_pkg::POS_RESERVE];
			nxt_i_scmp = spr_wdata_i[mmu_cfg_pkg::POS_STATE_CMP];
		end
		if (wr_d_ctl) begin
			nxt_d_gmode = spr_wdata_i[mmu_cfg_pkg::POS_GROUP_MODE];
			nxt_d_pmode = spr_wdata_i[mmu_cfg_pkg::POS_PAGE_MODE];
			nxt_d_inh = spr_wdata_i[mmu_cfg_pkg::POS_INHIBIT];
			nxt_d_wt = spr_wdata_i[mmu_cfg_pkg::POS_WRTHRU];
			nxt_d_rsv = spr_wdata_i[mmu_cfg_pkg::POS_RESERVE];
			nxt_d_walk = spr_wdata_i[mmu_cfg_pkg::POS_WALK];
			nxt_d_scmp = spr_wdata_i[mmu_cfg_pkg::POS_STATE_CMP];
		end
	end // R5

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			i_gmode_ff <= mmu_cfg_pkg::CTL_RESET;
			i_pmode_ff <= mmu_cfg_pkg::CTL_RESET;
			i_inh_ff <= mmu_cfg_pkg::CTL_RESET;
			i_rsv_ff <= mmu_cfg_pkg::CTL_RESET;
			i_scmp_ff <= mmu_cfg_pkg::CTL_RESET;
			d_gmode_ff <= mmu_cfg_pkg::CTL_RESET;
			d_pmode_ff <= mmu_cfg_pkg::CTL_RESET;
			d_inh_ff <= mmu_cfg_pkg::CTL_RESET;
			d_wt_ff <= mmu_cfg_pkg::CTL_RESET;
			d_rsv_ff <= mmu_cfg_pkg::CTL_RESET;
			d_walk_ff <= mmu_cfg_pkg::CTL_RESET;
			d_scmp_ff <= mmu_cfg_pkg::CTL_RESET;
		end else begin
			i_gmode_ff <= nxt_i_gmode;
			i_pmode_ff <= nxt_i_pmode;
			i_inh_ff <= nxt_i_inh;
			i_rsv_ff <= nxt_i_rsv;
			i_scmp_ff <= nxt_i_scmp;
			d_gmode_ff <= nxt_d_gmode;
			d_pmode_ff <= nxt_d_pmode;
			d_inh_ff <= nxt_d_inh;
			d_wt_ff <= nxt_d_wt;
			d_rsv_ff <= nxt_d_rsv;
			d_walk_ff <= nxt_d_walk;
			d_scmp_ff <= nxt_d_scmp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// replacement pointers
	replace_pointer u_instr_ptr (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.load_i(wr_i_ctl),
		.load_val_i(spr_wdata_i[mmu_cfg_pkg::POS_INDEX_LO +: mmu_cfg_pkg::PTR_W]),
		.step_i(ld_i_tlb), // R9
		.reserve_i(i_rsv_ff), // R6
		.ptr_o(i_ptr)
	);

	replace_pointer u_data_ptr (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.load_i(wr_d_ctl),
		.load_val_i(spr_wdata_i[mmu_cfg_pkg::POS_INDEX_LO +: mmu_cfg_pkg::PTR_W]),
		.step_i(ld_d_tlb), // R10
		.reserve_i(d_rsv_ff), // R7
		.ptr_o(d_ptr)
	);

	////////////////////////////////////////////////////////////////////////////////
	// group protection and space id, no reset
	logic [mmu_cfg_pkg::WORD_W-1:0] i_grp_ff, d_grp_ff, nxt_i_grp, nxt_d_grp;
	logic [mmu_cfg_pkg::SID_W-1:0] sid_ff, nxt_sid;

	always_comb begin
		nxt_i_grp = wr_i_grp ? spr_wdata_i : i_grp_ff; // R14
		nxt_d_grp = wr_d_grp ? spr_wdata_i : d_grp_ff; // R14
		nxt_sid = wr_sid ? spr_wdata_i[mmu_cfg_pkg::POS_SID_LO +: mmu_cfg_pkg::SID_W] : sid_ff; // R15
	end

	always_ff @(posedge clk_i) begin
		i_grp_ff <= nxt_i_grp; // R17
		d_grp_ff <= nxt_d_grp; // R17
		sid_ff <= nxt_sid; // R17
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path
	logic [mmu_cfg_pkg::WORD_W-1:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;

	always_comb begin
		nxt_rdata = '0;
		nxt_rvalid = spr_rd_i;
		if (spr_rd_i) begin
			case (spr_num_i)
				mmu_cfg_pkg::SPR_INSTR_CTL: begin
					nxt_rdata[mmu_cfg_pkg::POS_GROUP_MODE] = i_gmode_ff;
					nxt_rdata[mmu_cfg_pkg::POS_PAGE_MODE] = i_pmode_ff;
					nxt_rdata[mmu_cfg_pkg::POS_INHIBIT] = i_inh_ff;
					nxt_rdata[mmu_cfg_pkg::POS_RESERVE] = i_rsv_ff;
					nxt_rdata[mmu_cfg_pkg::POS_STATE_CMP] = i_scmp_ff;
					nxt_rdata[mmu_cfg_pkg::POS_INDEX_LO +: mmu_cfg_pkg::PTR_W] = i_ptr;
				end
				mmu_cfg_pkg::SPR_DATA_CTL: begin
					nxt_rdata[mmu_cfg_pkg::POS_GROUP_MODE] = d_gmode_ff;
					nxt_rdata[mmu_cfg_pkg::POS_PAGE_MODE] = d_pmode_ff;
					nxt_rdata[mmu_cfg_pkg::POS_INHIBIT] = d_inh_ff;
					nxt_rdata[mmu_cfg_pkg::POS_WRTHRU] = d_wt_ff;
					nxt_rdata[mmu_cfg_pkg::POS_RESERVE] = d_rsv_ff;
					nxt_rdata[mmu_cfg_pkg::POS_WALK] = d_walk_ff;
					nxt_rdata[mmu_cfg_pkg::POS_STATE_CMP] = d_scmp_ff;
					nxt_rdata[mmu_cfg_pkg::POS_INDEX_LO +: mmu_cfg_pkg::PTR_W] = d_ptr;
				end
				mmu_cfg_pkg::SPR_INSTR_GRP: begin
					nxt_rdata = i_grp_ff;
				end
				mmu_cfg_pkg::SPR_DATA_GRP: begin
					nxt_rdata = d_grp_ff;
				end
				mmu_cfg_pkg::SPR_SPACE_ID: begin
					nxt_rdata[mmu_cfg_pkg::POS_SID_LO +: mmu_cfg_pkg::SID_W] = sid_ff;
				end
				default: begin
					nxt_rdata = '0;
				end
			endcase
		end
	end // R5

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= '0;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// group code decode: {deny, check pages, effective problem}
	function automatic logic [2:0] decode_group(
		input logic domain_mode,
		input logic [mmu_cfg_pkg::CODE_W-1:0] code,
		input logic problem
	);
		logic [2:0] res;
		res = {1'b0, 1'b1, problem};
		if (domain_mode) begin
			case (code)
				mmu_cfg_pkg::CODE_00: res = {1'b1, 1'b0, problem};
				mmu_cfg_pkg::CODE_01: res = {1'b0, 1'b1, problem};
				mmu_cfg_pkg::CODE_11: res = {1'b0, 1'b0, problem};
				default: res = {1'b1, 1'b0, problem};
			endcase // R12
		end else begin
			case (code)
				mmu_cfg_pkg::CODE_00: res = {1'b0, 1'b1, 1'b0};
				mmu_cfg_pkg::CODE_01: res = {1'b0, 1'b1, problem};
				mmu_cfg_pkg::CODE_10: res = {1'b0, 1'b1, ~problem};
				default: res = {1'b0, 1'b1, 1'b1};
			endcase // R13
		end
		return res;
	endfunction

	function automatic logic state_ok(
		input logic cmp_mode,
		input logic [mmu_cfg_pkg::STATE_W-1:0] st,
		input logic problem
	);
		return !cmp_mode || (problem ? st[mmu_cfg_pkg::POS_ST_PROB]
			: st[mmu_cfg_pkg::POS_ST_PRIV]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// lookup answers
	logic [2:0] i_dec, d_dec;
	logic [2:0] i_dec_ff, d_dec_ff;
	logic i_qual_ff, d_qual_ff, nxt_i_qual, nxt_d_qual;
	logic i_inh_out_ff, d_inh_out_ff, d_wt_out_ff;
	logic nxt_i_inh_out, nxt_d_inh_out, nxt_d_wt_out;

	always_comb begin
		i_dec = decode_group(i_gmode_ff,
			i_grp_ff[mmu_cfg_pkg::WORD_W-1 - mmu_cfg_pkg::CODE_W*instr_group_i -: mmu_cfg_pkg::CODE_W],
			instr_problem_i); // R1
		d_dec = decode_group(d_gmode_ff,
			d_grp_ff[mmu_cfg_pkg::WORD_W-1 - mmu_cfg_pkg::CODE_W*data_group_i -: mmu_cfg_pkg::CODE_W],
			data_problem_i); // R1
		nxt_i_qual = (instr_global_entry_flag_i || instr_entry_space_id_i == sid_ff) // R16
			&& state_ok(i_scmp_ff, instr_entry_state_i, instr_problem_i); // R8
		nxt_d_qual = (data_global_entry_flag_i || data_entry_space_id_i == sid_ff) // R16
			&& state_ok(d_scmp_ff, data_entry_state_i, data_problem_i); // R8
		nxt_i_inh_out = instr_xlate_en_i ? instr_entry_ci_i : i_inh_ff; // R3
		nxt_d_inh_out = data_xlate_en_i ? data_entry_ci_i : d_inh_ff; // R4
		nxt_d_wt_out = data_xlate_en_i ? data_entry_wt_i : d_wt_ff; // R4
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			i_dec_ff <= '0;
			d_dec_ff <= '0;
			i_qual_ff <= 1'b0;
			d_qual_ff <= 1'b0;
			i_inh_out_ff <= 1'b0;
			d_inh_out_ff <= 1'b0;
			d_wt_out_ff <= 1'b0;
		end else begin
			i_dec_ff <= i_dec;
			d_dec_ff <= d_dec;
			i_qual_ff <= nxt_i_qual;
			d_qual_ff <= nxt_d_qual;
			i_inh_out_ff <= nxt_i_inh_out;
			d_inh_out_ff <= nxt_d_inh_out;
			d_wt_out_ff <= nxt_d_wt_out;
		end
	end

	assign instr_deny_o = i_dec_ff[2];
	assign instr_check_pages_o = i_dec_ff[1];
	assign instr_eff_problem_o = i_dec_ff[0];
	assign instr_hit_qual_o = i_qual_ff;
	assign instr_fetch_inhibit_o = i_inh_out_ff;
	assign data_deny_o = d_dec_ff[2];
	assign data_check_pages_o = d_dec_ff[1];
	assign data_eff_problem_o = d_dec_ff[0];
	assign data_hit_qual_o = d_qual_ff;
	assign data_access_inhibit_o = d_inh_out_ff;
	assign data_access_wrthru_o = d_wt_out_ff;
	assign instr_subpage_mode_o = i_pmode_ff; // R2
	assign data_subpage_mode_o = d_pmode_ff; // R2
	assign walk_assist_size_o = d_walk_ff; // R11
	assign instr_replace_pointer_o = i_ptr;
	assign data_replace_pointer_o = d_ptr;
	assign spr_rdata_o = rdata_ff;
	assign spr_rvalid_o = rvalid_ff;
endmodule
`default_nettype wire

// File: verilog/mmu_cfg_pkg.sv
// Purpose: shared constants for the translation configuration register set
// Assumes: big-endian bit numbering maps bit n to vector position 31-n
// Notes: special-register numbers are arbitrary codes for this block
package mmu_cfg_pkg;
	localparam int unsigned SPR_W = 10;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned PTR_W = 3;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned SID_W = 4;
	localparam int unsigned GRP_W = 4;
	localparam int unsigned CODE_W = 2;
	localparam int unsigned STATE_W = 4;

	// special-register numbers (arbitrary values)
	localparam logic [SPR_W-1:0] SPR_INSTR_CTL = 10'h301;
	localparam logic [SPR_W-1:0] SPR_INSTR_GRP = 10'h302;
	localparam logic [SPR_W-1:0] SPR_INSTR_RPN = 10'h303;
	localparam logic [SPR_W-1:0] SPR_DATA_CTL = 10'h311;
	localparam logic [SPR_W-1:0] SPR_DATA_GRP = 10'h312;
	localparam logic [SPR_W-1:0] SPR_DATA_RPN = 10'h313;
	localparam logic [SPR_W-1:0] SPR_SPACE_ID = 10'h321;

	// control register field positions
	localparam int unsigned POS_GROUP_MODE = 31;
	localparam int unsigned POS_PAGE_MODE = 30;
	localparam int unsigned POS_INHIBIT = 29;
	localparam int unsigned POS_WRTHRU = 28;
	localparam int unsigned POS_RESERVE = 27;
	localparam int unsigned POS_WALK = 26;
	localparam int unsigned POS_STATE_CMP = 25;
	localparam int unsigned POS_INDEX_LO = 8;
	localparam int unsigned POS_SID_LO = 0;

	localparam logic CTL_RESET = 1'h0;
	localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
	localparam logic [PTR_W-1:0] PTR_TOP_FULL = 3'h7;
	localparam logic [PTR_W-1:0] PTR_TOP_RSV = 3'h5;
	localparam logic [PTR_W-1:0] PTR_ZERO = 3'h0;
	localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;

	// group permission codes
	localparam logic [CODE_W-1:0] CODE_00 = 2'h0;
	localparam logic [CODE_W-1:0] CODE_01 = 2'h1;
	localparam logic [CODE_W-1:0] CODE_10 = 2'h2;
	localparam logic [CODE_W-1:0] CODE_11 = 2'h3;

	// positions inside the entry state nibble (entry bits 24..27)
	localparam int unsigned POS_ST_PRIV = 3;
	localparam int unsigned POS_ST_PROB = 2;
endpackage

// File: verilog/replace_pointer.sv
// Purpose: tlb replacement pointer that counts down with optional reservation
// Assumes: load and step never come in the same cycle from software
// Notes: a load takes priority over a step
`timescale 1ns/100ps
`default_nettype none
module replace_pointer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [mmu_cfg_pkg::PTR_W-1:0] load_val_i,
	input wire logic step_i,
	input wire logic reserve_i,
	output logic [mmu_cfg_pkg::PTR_W-1:0] ptr_o
);
	logic [mmu_cfg_pkg::PTR_W-1:0] ptr_ff;
	logic [mmu_cfg_pkg::PTR_W-1:0] nxt_ptr;

	always_comb begin
		nxt_ptr = ptr_ff;
		if (load_i) begin
			nxt_ptr = load_val_i;
		end else if (step_i) begin
			if (ptr_ff == mmu_cfg_pkg::PTR_ZERO) begin
				nxt_ptr = reserve_i ? mmu_cfg_pkg::PTR_TOP_RSV : mmu_cfg_pkg::PTR_TOP_FULL; // R19
			end else begin
				nxt_ptr = ptr_ff - mmu_cfg_pkg::PTR_ONE;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_ff <= mmu_cfg_pkg::PTR_RESET;
		end else begin
			ptr_ff <= nxt_ptr;
		end
	end

	assign ptr_o = ptr_ff;
endmodule
`default_nettype wire

// File: verification/mmu_cfg_props.sv
// Purpose: assertions for the translation configuration register block
// Assumes: shadow copies follow the special-register writes seen at the ports
// Notes: lookup outputs lag their inputs by one cycle
`timescale 1ns/100ps
`default_nettype none
module mmu_cfg_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic spr_wr_i,
	input wire logic spr_rd_i,
	input wire logic [9:0] spr_num_i,
	input wire logic [31:0] spr_wdata_i,
	input wire logic [31:0] spr_rdata_o,
	input wire logic instr_xlate_en_i,
	input wire logic data_xlate_en_i,
	input wire logic [3:0] instr_group_i,
	input wire logic instr_problem_i,
	input wire logic instr_entry_ci_i,
	input wire logic [3:0] instr_entry_space_id_i,
	input wire logic instr_global_entry_flag_i,
	input wire logic [3:0] instr_entry_state_i,
	input wire logic instr_deny_o,
	input wire logic instr_eff_problem_o,
	input wire logic instr_hit_qual_o,
	input wire logic instr_fetch_inhibit_o,
	input wire logic data_entry_ci_i,
	input wire logic data_entry_wt_i,
	input wire logic data_access_inhibit_o,
	input wire logic data_access_wrthru_o,
	input wire logic instr_subpage_mode_o,
	input wire logic data_subpage_mode_o,
	input wire logic walk_assist_size_o,
	input wire logic [2:0] instr_replace_pointer_o,
	input wire logic [2:0] data_replace_pointer_o
);
	logic run_ff, gok_ff, sok_ff;
	logic [31:0] ictl_ff, dctl_ff, grp_ff;
	logic [3:0] sid_ff;
	logic [1:0] code;
	logic eff;
	logic hit;
	////////////////////////////////////////////////////////////////////////////////
	// shadows of the written control, instruction group and space id registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_ff <= 1'b0;
			gok_ff <= 1'b0;
			sok_ff <= 1'b0;
			ictl_ff <= 32'h0;
			dctl_ff <= 32'h0;
		end else begin
			run_ff <= 1'b1;
			if (spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_INSTR_CTL) ictl_ff <= spr_wdata_i;
			if (spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_DATA_CTL) dctl_ff <= spr_wdata_i;
			if (spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_INSTR_GRP) grp_ff <= spr_wdata_i;
			if (spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_SPACE_ID) sid_ff <= spr_wdata_i[3:0];
			gok_ff <= gok_ff | (spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_INSTR_GRP);
			sok_ff <= sok_ff | (spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_SPACE_ID);
		end
	end
	assign code = 2'(grp_ff >> (5'd30 - {instr_group_i, 1'b0}));
	assign eff = ictl_ff[31] ? instr_problem_i : (code == 2'h0 ? 1'b0 :
		code == 2'h1 ? instr_problem_i : code == 2'h2 ? !instr_problem_i : 1'b1);
	assign hit = (instr_global_entry_flag_i || instr_entry_space_id_i == sid_ff) &&
		(!ictl_ff[25] || (instr_problem_i ? instr_entry_state_i[2] : instr_entry_state_i[3]));
	////////////////////////////////////////////////////////////////////////////////
	// properties
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_ctl_rd;
		spr_rd_i && (spr_num_i == mmu_cfg_pkg::SPR_INSTR_CTL || spr_num_i == mmu_cfg_pkg::SPR_DATA_CTL);
	endsequence
	sequence s_irpn;
		spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_INSTR_RPN;
	endsequence
	sequence s_drpn;
		spr_wr_i && spr_num_i == mmu_cfg_pkg::SPR_DATA_RPN;
	endsequence
	a_fetch_inhibit_default: assert property (run_ff |=> instr_fetch_inhibit_o ==
		$past(instr_xlate_en_i ? instr_entry_ci_i : ictl_ff[29]))
		else $error("fetch inhibit attribute wrong");
	a_data_attr_default: assert property (run_ff |=> {data_access_inhibit_o,
		data_access_wrthru_o} == $past(data_xlate_en_i ? {data_entry_ci_i, data_entry_wt_i}
		: dctl_ff[29:28])) else $error("data attributes wrong");
	a_ctl_reserved_zero: assert property (s_ctl_rd |=> (spr_rdata_o & 32'h01FFF8FF) == 32'h0)
		else $error("reserved control bits read nonzero");
	a_ipointer_step: assert property (s_irpn |=> instr_replace_pointer_o ==
		($past(instr_replace_pointer_o) == 3'h0 ? ($past(ictl_ff[27]) ? 3'h5 : 3'h7)
		: $past(instr_replace_pointer_o) - 3'h1)) else $error("instruction pointer step wrong");
	a_dpointer_step: assert property (s_drpn |=> data_replace_pointer_o ==
		($past(data_replace_pointer_o) == 3'h0 ? ($past(dctl_ff[27]) ? 3'h5 : 3'h7)
		: $past(data_replace_pointer_o) - 3'h1)) else $error("data pointer step wrong");
	a_group_deny: assert property (run_ff && gok_ff |=>
		instr_deny_o == $past(ictl_ff[31] && !code[0])) else $error("group deny wrong");
	a_key_problem: assert property (run_ff && gok_ff |=> instr_eff_problem_o == $past(eff))
		else $error("effective state wrong");
	a_space_hit: assert property (run_ff && sok_ff |=> instr_hit_qual_o == $past(hit))
		else $error("hit qualifier wrong");
	a_mode_levels: assert property (run_ff && $stable(ictl_ff) && $stable(dctl_ff) |->
		{instr_subpage_mode_o, data_subpage_mode_o, walk_assist_size_o} ==
		{ictl_ff[30], dctl_ff[30], dctl_ff[26]}) else $error("mode levels wrong");
endmodule
bind mmu_config_protection_regs mmu_cfg_props chk (.*);
`default_nettype wire

// File: verification/mmu_config_protection_regs_tb_top.sv
// Purpose: self-checking bench for the translation configuration registers
// Assumes: register moves are one-cycle strobes with a gap cycle between
// Notes: read data is scored against a queue of expected words
`timescale 1ns/100ps
`default_nettype none
module mmu_config_protection_regs_tb_top;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic spr_wr_i = 1'b0;
	logic spr_rd_i = 1'b0;
	logic [9:0] spr_num_i = 10'h0;
	logic [31:0] spr_wdata_i = 32'h0;
	logic [31:0] spr_rdata_o;
	logic spr_rvalid_o;
	logic instr_xlate_en_i, data_xlate_en_i, instr_problem_i, data_problem_i, instr_entry_ci_i;
	logic data_entry_ci_i, data_entry_wt_i, instr_global_entry_flag_i, data_global_entry_flag_i;
	logic [3:0] instr_group_i, data_group_i, instr_entry_state_i, data_entry_state_i;
	logic [3:0] instr_entry_space_id_i, data_entry_space_id_i;
	logic [3:0] sid = 4'h0;
	logic instr_deny_o, instr_check_pages_o, instr_eff_problem_o, instr_hit_qual_o;
	logic data_deny_o, data_check_pages_o, data_eff_problem_o, data_hit_qual_o;
	logic instr_fetch_inhibit_o, data_access_inhibit_o, data_access_wrthru_o;
	logic instr_subpage_mode_o, data_subpage_mode_o, walk_assist_size_o;
	logic [2:0] instr_replace_pointer_o, data_replace_pointer_o, pexp, at;
	logic [31:0] ictl, dctl, igrp, dgrp;
	logic [31:0] expq[$];
	logic [3:0] ie, de;
	int n_errors = 0;
	int tests_run = 0;
	int seed = 29;
	always #4 clk_i = ~clk_i;
	mmu_config_protection_regs uut (.*);
	////////////////////////////////////////////////////////////////////////////////
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [9:0] num, input logic [31:0] d);
		{instr_xlate_en_i, data_xlate_en_i} = 2'h0;
		spr_num_i = num;
		spr_wdata_i = d;
		spr_wr_i = 1'b1;
		@(posedge clk_i);
		#1 spr_wr_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic rd(input logic [9:0] num, input logic [31:0] exp);
		{instr_xlate_en_i, data_xlate_en_i} = 2'h0;
		spr_num_i = num;
		spr_rd_i = 1'b1;
		expq.push_back(exp);
		@(posedge clk_i);
		#1 spr_rd_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic rand_look();
		{instr_xlate_en_i, data_xlate_en_i, instr_problem_i, data_problem_i, instr_entry_ci_i,
			data_entry_ci_i, data_entry_wt_i, instr_global_entry_flag_i,
			data_global_entry_flag_i} = 9'($random(seed));
		{instr_group_i, data_group_i, instr_entry_state_i, data_entry_state_i} = 16'($random(seed));
		instr_entry_space_id_i = $random(seed) % 2 ? sid : 4'($random(seed));
		data_entry_space_id_i = $random(seed) % 2 ? sid : 4'($random(seed));
	endtask
	function automatic logic [3:0] look(input logic [31:0] ctl, input logic [31:0] grp,
		input logic [3:0] g, input logic p, input logic [3:0] id, input logic gl,
		input logic [3:0] st);
		logic [1:0] c;
		logic e;
		c = grp[31 - 2 * int'(g) -: 2];
		e = ctl[31] ? p : (c == 2'h0 ? 1'b0 : c == 2'h1 ? p : c == 2'h2 ? !p : 1'b1);
		look = {ctl[31] & !c[0], !ctl[31] | c == 2'h1, e,
			(gl | id == sid) & (!ctl[25] | (p ? st[2] : st[3]))};
	endfunction
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// read data scoreboard
	always @(posedge clk_i) begin
		#2;
		if (spr_rvalid_o === 1'b1) begin
			if (expq.size() == 0) chk(32'(expq.size()), 32'h1);
			else chk(spr_rdata_o, expq.pop_front());
		end
	end
	initial begin
		#100000;
		n_errors++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		complete_run();
	end
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rand_look();
		repeat (5) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		rd(mmu_cfg_pkg::SPR_INSTR_CTL, 32'h0);
		rd(mmu_cfg_pkg::SPR_DATA_CTL, 32'h0);
		wr(mmu_cfg_pkg::SPR_INSTR_CTL, 32'hFFFFFFFF);
		rd(mmu_cfg_pkg::SPR_INSTR_CTL, 32'hEA000700);
		wr(mmu_cfg_pkg::SPR_DATA_CTL, 32'hFFFFFFFF);
		rd(mmu_cfg_pkg::SPR_DATA_CTL, 32'hFE000700);
		wr(10'h3FF, 32'hFFFFFFFF);
		rd(10'h3FF, 32'h0);
		for (int s = 0; s < 2; s++) begin
			for (int r = 0; r < 2; r++) begin
				wr(s ? mmu_cfg_pkg::SPR_DATA_CTL : mmu_cfg_pkg::SPR_INSTR_CTL, 32'(r << 27) | 32'h700);
				pexp = 3'h7;
				repeat (9) begin
					wr(s ? mmu_cfg_pkg::SPR_DATA_RPN : mmu_cfg_pkg::SPR_INSTR_RPN, 32'($random(seed)));
					pexp = pexp == 3'h0 ? (r ? 3'h5 : 3'h7) : pexp - 3'h1;
					chk(s ? data_replace_pointer_o : instr_replace_pointer_o, pexp);
				end
			end
		end
		for (int n = 0; n < 6; n++) begin
			ictl = {n[0], 31'($random(seed))};
			dctl = {!n[0], 31'($random(seed))};
			igrp = $random(seed);
			dgrp = $random(seed);
			sid = 4'($random(seed));
			wr(mmu_cfg_pkg::SPR_INSTR_CTL, ictl);
			wr(mmu_cfg_pkg::SPR_DATA_CTL, dctl);
			wr(mmu_cfg_pkg::SPR_INSTR_GRP, igrp);
			wr(mmu_cfg_pkg::SPR_DATA_GRP, dgrp);
			wr(mmu_cfg_pkg::SPR_SPACE_ID, {28'($random(seed)), sid});
			rd(mmu_cfg_pkg::SPR_INSTR_GRP, igrp);
			rd(mmu_cfg_pkg::SPR_DATA_GRP, dgrp);
			rd(mmu_cfg_pkg::SPR_SPACE_ID, {28'h0, sid});
			repeat (40) begin
				rand_look();
				ie = look(ictl, igrp, instr_group_i, instr_problem_i, instr_entry_space_id_i,
					instr_global_entry_flag_i, instr_entry_state_i);
				de = look(dctl, dgrp, data_group_i, data_problem_i, data_entry_space_id_i,
					data_global_entry_flag_i, data_entry_state_i);
				at = {instr_xlate_en_i ? instr_entry_ci_i : ictl[29],
					data_xlate_en_i ? {data_entry_ci_i, data_entry_wt_i} : dctl[29:28]};
				@(posedge clk_i);
				#1;
				chk({instr_deny_o, instr_eff_problem_o, instr_hit_qual_o, data_deny_o, data_eff_problem_o,
					data_hit_qual_o}, {ie[3], ie[1:0], de[3], de[1:0]});
				if (!ie[3]) chk(instr_check_pages_o, ie[2]);
				if (!de[3]) chk(data_check_pages_o, de[2]);
				chk({instr_fetch_inhibit_o, data_access_inhibit_o, data_access_wrthru_o}, at);
				chk({instr_subpage_mode_o, data_subpage_mode_o, walk_assist_size_o},
					{ictl[30], dctl[30], dctl[26]});
			end
		end
		rst_n_i = 1'b0;
		@(posedge clk_i);
		#1 rst_n_i = 1'b1;
		chk({instr_replace_pointer_o, data_replace_pointer_o}, 32'h0);
		rd(mmu_cfg_pkg::SPR_DATA_CTL, 32'h0);
		rd(mmu_cfg_pkg::SPR_INSTR_GRP, igrp);
		#2;
		chk(32'(expq.size()), 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
